// ---- rtl/ssp_pkg.sv ----
package ssp_pkg;

    // ----------------------------------------------------------------
    // sizes and timing
    // ----------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ENH_DEPTH = 8;
    localparam int STD_DEPTH = 1;
    localparam int DIV_W = 8;
    // half period floor: the two-stage input sync must settle first
    localparam logic [7:0] MIN_HALF = 8'h03;
    localparam logic [7:0] DIV_RESET = 8'h03;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SSP_PINS_2 = 2'h0,
        SSP_PINS_3 = 2'h1,
        SSP_PINS_4 = 2'h2
    } ssp_pins_t;

    typedef enum logic [3:0] {
        SSP_IDLE = 4'h1,
        SSP_FRAME = 4'h2,
        SSP_SHIFT = 4'h4,
        SSP_GAP = 4'h8
    } ssp_state_t;

    typedef struct packed {
        logic port_enable;
        logic master_select;
        logic enhanced_mode;
        ssp_pins_t pins;
        logic select_pin_enable;
        logic clock_idle_high;
        logic input_sample_phase;
        logic frame_enable;
        logic frame_active_high;
    } ssp_cfg_t;

    typedef struct packed {
        logic o;
        logic oe_n;
    } ssp_pin_t;

endpackage

// ---- rtl/ssp_port.sv ----
// Operation
// (R1) standard mode holds one word buffered
// (R2) enhanced mode queues through eight-entry fifo
// (R3) framed transfers as master or slave, four ways
// (R4) data in, data out, clock, select/frame pins
// (R5) two, three or four pin wiring
// (R6) two-pin: no data out, no select
// (R7) master starts shifting once word written
// (R8) software sets master bit before enabling
// (R9) software clears overflow before enabling
// (R10) software enables port as last step
// (R11) software clears master bit for slave
// (R12) software clears buffer before slave setup
// (R13) software clears sample phase for slave
// (R14) software sets select enable when needed
// (R15) software prepares interrupt before enabling
// (R16) no read-modify-write on transfer buffer
// (R17) one or two identical port instances
// (R18) unused select pin is ignored
`timescale 1ns/10ps

// ------------------------------------------------------------------------
// fifo with run-time capacity limit
// ------------------------------------------------------------------------
module ssp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [CW-1:0] cap,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = cnt_q < cap;
    assign out_valid = cnt_q != '0;
    assign out_data = mem_q[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push)
        begin
            wp_d = (int'(wp_q) == DEPTH - 1) ? '0 : wp_q + 1'b1;
        end
        if (pop)
        begin
            rp_d = (int'(rp_q) == DEPTH - 1) ? '0 : rp_q + 1'b1;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else if (ce)
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (ce && push)
        begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule

// ------------------------------------------------------------------------
// serial port; instantiate once per port wanted [R17]
// ------------------------------------------------------------------------
module ssp_port #(
    parameter int W = ssp_pkg::DATA_W,
    parameter int DEPTH = ssp_pkg::ENH_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic link_clk,
    input wire ssp_pkg::ssp_cfg_t cfg,
    input wire logic [ssp_pkg::DIV_W-1:0] half_period,
    input wire logic [W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [W-1:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic overflow_clear,
    output logic receive_overflow_flag,
    output logic busy,
    input wire logic serial_in_pin,
    output ssp_pkg::ssp_pin_t serial_out_pin,
    input wire logic shift_clock_pin_i,
    output ssp_pkg::ssp_pin_t shift_clock_pin,
    input wire logic select_or_frame_pin_i,
    output ssp_pkg::ssp_pin_t select_or_frame_pin
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int BW = $clog2(W + 1);

    // ------------------------------------------------------------------
    // buffers
    // ------------------------------------------------------------------
    logic [CW-1:0] cap;
    logic [W-1:0] txf_data, rxw, sl_rxw;
    logic txf_valid, txf_pop, tx_pop, rx_push, rxf_ready;
    logic is_master, is_slave;

    assign is_master = cfg.port_enable && cfg.master_select;
    assign is_slave = cfg.port_enable && !cfg.master_select;
    // [R1] [R2]
    assign cap = cfg.enhanced_mode ? CW'(DEPTH) : CW'(ssp_pkg::STD_DEPTH);

    ssp_fifo #(.W(W), .DEPTH(DEPTH)) u_txf (
        .clk(ref_clk), .rst_n(rst_n), .ce(clk_en), .cap(cap),
        .in_valid(tx_valid), .in_ready(tx_ready), .in_data(tx_data),
        .out_valid(txf_valid), .out_ready(tx_pop), .out_data(txf_data)
    );
    ssp_fifo #(.W(W), .DEPTH(DEPTH)) u_rxf (
        .clk(ref_clk), .rst_n(rst_n), .ce(clk_en), .cap(cap),
        .in_valid(rx_push), .in_ready(rxf_ready), .in_data(rxw),
        .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data)
    );

    // ------------------------------------------------------------------
    // input synchronisers (ref domain)
    // ------------------------------------------------------------------
    logic [1:0] sin_q, ack_q;
    logic [2:0] rxt_q;
    logic sl_ack, sl_rxt, sin_s;
    assign sin_s = sin_q[1];

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sin_q <= 2'h0;
            ack_q <= 2'h0;
            rxt_q <= 3'h0;
        end
        else if (clk_en)
        begin
            sin_q <= {sin_q[0], serial_in_pin};
            ack_q <= {ack_q[0], sl_ack};
            rxt_q <= {rxt_q[1:0], sl_rxt};
        end
    end

    // ------------------------------------------------------------------
    // master engine
    // ------------------------------------------------------------------
    ssp_pkg::ssp_state_t st_q, st_d;
    logic [ssp_pkg::DIV_W-1:0] div_q, div_d, half_lim;
    logic [BW-1:0] bit_q, bit_d;
    logic [W-1:0] sh_q, sh_d;
    logic half_q, half_d, mid_q, mid_d, tick, m_push;
    logic ovf_q, ovf_d, m_rst;

    assign half_lim = (half_period < ssp_pkg::MIN_HALF) ?
        ssp_pkg::MIN_HALF : half_period;
    assign tick = div_q == half_lim - 1'b1;

    always_comb
    begin
        st_d = st_q;
        div_d = tick ? '0 : div_q + 1'b1;
        bit_d = bit_q;
        sh_d = sh_q;
        half_d = half_q;
        mid_d = mid_q;
        txf_pop = 1'b0;
        m_push = 1'b0;
        m_rst = 1'b0;
        case (st_q)
            ssp_pkg::SSP_IDLE:
            begin
                div_d = '0;
                half_d = 1'b0;
                bit_d = '0;
                if (is_master && txf_valid)
                begin
                    // [R7]
                    txf_pop = 1'b1;
                    sh_d = txf_data;
                    st_d = cfg.frame_enable ? ssp_pkg::SSP_FRAME :
                        ssp_pkg::SSP_SHIFT; // [R3]
                end
            end
            ssp_pkg::SSP_FRAME:
            begin
                if (tick)
                begin
                    half_d = !half_q;
                    if (half_q)
                    begin
                        st_d = ssp_pkg::SSP_SHIFT;
                    end
                end
            end
            ssp_pkg::SSP_SHIFT:
            begin
                if (tick)
                begin
                    half_d = !half_q;
                    if (!half_q)
                    begin
                        mid_d = sin_s;
                    end
                    else
                    begin
                        sh_d = {sh_q[W-2:0],
                            cfg.input_sample_phase ? sin_s : mid_q};
                        bit_d = bit_q + 1'b1;
                        if (int'(bit_q) == W - 1)
                        begin
                            m_push = 1'b1;
                            st_d = ssp_pkg::SSP_GAP;
                        end
                    end
                end
            end
            ssp_pkg::SSP_GAP:
            begin
                if (tick)
                begin
                    st_d = ssp_pkg::SSP_IDLE;
                end
            end
            default:
            begin
                m_rst = 1'b1;
                st_d = ssp_pkg::SSP_IDLE;
            end
        endcase
        if (!is_master && !m_rst)
        begin
            st_d = ssp_pkg::SSP_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // slave feed: one word handed across per toggle
    // ------------------------------------------------------------------
    logic req_q, req_d;
    logic [W-1:0] hold_q, hold_d;
    logic s_push;
    assign s_push = rxt_q[1] ^ rxt_q[2];

    always_comb
    begin
        req_d = req_q;
        hold_d = hold_q;
        if (is_slave && txf_valid && (req_q == ack_q[1]))
        begin
            hold_d = txf_data;
            req_d = !req_q;
        end
    end

    assign rx_push = m_push || s_push;
    assign rxw = m_push ? sh_d : sl_rxw;

    always_comb
    begin
        ovf_d = ovf_q;
        if (overflow_clear)
        begin
            ovf_d = 1'b0;
        end
        // set beats clear; the late word is dropped
        if (rx_push && !rxf_ready)
        begin
            ovf_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= ssp_pkg::SSP_IDLE;
            div_q <= '0;
            bit_q <= '0;
            sh_q <= '0;
            half_q <= 1'b0;
            mid_q <= 1'b0;
            ovf_q <= 1'b0;
            req_q <= 1'b0;
            hold_q <= '0;
        end
        else if (clk_en)
        begin
            st_q <= st_d;
            div_q <= div_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            half_q <= half_d;
            mid_q <= mid_d;
            ovf_q <= ovf_d;
            req_q <= req_d;
            hold_q <= hold_d;
        end
    end

    // the feed pop shares the tx fifo port with the master engine
    logic feed_pop;
    assign feed_pop = req_d != req_q;
    assign tx_pop = txf_pop || feed_pop;

    // ------------------------------------------------------------------
    // slave engine on the partner's shift clock
    // ------------------------------------------------------------------
    logic [BW-1:0] lcnt_q, lcnt_d;
    logic [W-1:0] lsh_q, lsh_d, txw;
    logic lack_q, lack_d, lrxt_q, lrxt_d, arm_q, arm_d;
    logic fresh, go, ss_act, fr_hit, l_en, l_ss, l_fe;

    assign sl_ack = lack_q;
    assign sl_rxt = lrxt_q;
    // the shift clock stops between words, so a chain clocked by it
    // would lag; cfg and the hand-over toggle are steady by then
    assign l_en = is_slave;
    assign l_ss = cfg.pins == ssp_pkg::SSP_PINS_4 &&
        cfg.select_pin_enable && !cfg.frame_enable; // [R5]
    assign l_fe = cfg.frame_enable;
    assign fresh = req_q != lack_q;
    assign txw = fresh ? hold_q : '0;
    // select and frame travel with the shift clock, so no sync on them
    assign ss_act = !select_or_frame_pin_i; // [R4]
    assign fr_hit = select_or_frame_pin_i == cfg.frame_active_high;
    // [R18]
    assign go = l_en && (!l_ss || ss_act) &&
        (!l_fe || arm_q || lcnt_q != '0);

    always_comb
    begin
        lcnt_d = lcnt_q;
        lsh_d = lsh_q;
        lack_d = lack_q;
        lrxt_d = lrxt_q;
        arm_d = arm_q;
        if (l_en && l_fe && !arm_q && lcnt_q == '0 && fr_hit)
        begin
            arm_d = 1'b1; // [R3]
        end
        else if (go)
        begin
            lsh_d = {(lcnt_q == '0) ? txw[W-2:0] : lsh_q[W-2:0],
                serial_in_pin};
            if (lcnt_q == '0)
            begin
                lack_d = req_q;
            end
            lcnt_d = lcnt_q + 1'b1;
            if (int'(lcnt_q) == W - 1)
            begin
                lcnt_d = '0;
                lrxt_d = !lrxt_q;
                arm_d = 1'b0;
            end
        end
        else if (!l_en || l_ss)
        begin
            lcnt_d = '0;
        end
    end

    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lcnt_q <= '0;
            lsh_q <= '0;
            lack_q <= 1'b0;
            lrxt_q <= 1'b0;
            arm_q <= 1'b0;
            sl_rxw <= '0;
        end
        else
        begin
            lcnt_q <= lcnt_d;
            lsh_q <= lsh_d;
            lack_q <= lack_d;
            lrxt_q <= lrxt_d;
            arm_q <= arm_d;
            if (lrxt_d != lrxt_q)
            begin
                sl_rxw <= lsh_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // pins and status
    // ------------------------------------------------------------------
    logic active, frame_pin, sel_pin;
    assign active = st_q == ssp_pkg::SSP_FRAME ||
        st_q == ssp_pkg::SSP_SHIFT;
    assign frame_pin = (st_q == ssp_pkg::SSP_FRAME) ?
        cfg.frame_active_high : !cfg.frame_active_high;
    assign sel_pin = cfg.frame_enable ? frame_pin :
        !(active || st_q == ssp_pkg::SSP_GAP);

    always_comb
    begin
        serial_out_pin.o = is_master ? sh_q[W-1] :
            ((lcnt_q == '0) ? txw[W-1] : lsh_q[W-1]);
        serial_out_pin.oe_n = !(cfg.port_enable &&
            cfg.pins != ssp_pkg::SSP_PINS_2); // [R6]
        shift_clock_pin.o = cfg.clock_idle_high ^
            (active && half_q);
        shift_clock_pin.oe_n = !is_master;
        select_or_frame_pin.o = sel_pin;
        select_or_frame_pin.oe_n = !(is_master &&
            cfg.pins == ssp_pkg::SSP_PINS_4); // [R5] [R6]
    end

    assign receive_overflow_flag = ovf_q;
    assign busy = (st_q != ssp_pkg::SSP_IDLE) || (req_q != ack_q[1]);
endmodule

// ---- tb/ssp_port_properties.sv ----
`timescale 1ns/10ps

// --------------------------------------------------------------
// port checker
// --------------------------------------------------------------
module ssp_port_properties #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire ssp_pkg::ssp_cfg_t cfg,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [W-1:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic overflow_clear,
    input wire logic receive_overflow_flag,
    input wire logic busy,
    input wire ssp_pkg::ssp_pin_t serial_out_pin,
    input wire ssp_pkg::ssp_pin_t shift_clock_pin,
    input wire ssp_pkg::ssp_pin_t select_or_frame_pin
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence word_taken;
        tx_valid && tx_ready && clk_en && !busy && cfg.port_enable
            && cfg.master_select && !cfg.frame_enable
            && cfg.pins == ssp_pkg::SSP_PINS_4;
    endsequence
    sequence select_low_run;
        !select_or_frame_pin.o [*8];
    endsequence

    master_start_a: assert property (word_taken
        |-> ##[1:3] select_low_run)
        else $error("select did not drop after a written word");
    two_pin_a: assert property (cfg.pins == ssp_pkg::SSP_PINS_2
        |-> serial_out_pin.oe_n && select_or_frame_pin.oe_n)
        else $error("two-pin wiring drives data out or select");
    three_pin_a: assert property (cfg.port_enable
        && cfg.pins == ssp_pkg::SSP_PINS_3
        |-> select_or_frame_pin.oe_n && !serial_out_pin.oe_n)
        else $error("three-pin wiring has wrong pin drive");
    master_clock_a: assert property (cfg.port_enable
        && cfg.master_select |-> !shift_clock_pin.oe_n)
        else $error("master does not drive the shift clock");
    slave_clock_a: assert property (!cfg.master_select
        |-> shift_clock_pin.oe_n)
        else $error("slave drives the shift clock");
    single_slot_a: assert property (!cfg.port_enable
        && !cfg.enhanced_mode && tx_valid && tx_ready && clk_en
        ##1 $stable(cfg) |-> !tx_ready)
        else $error("standard buffer took a second word");
    flag_hold_a: assert property (receive_overflow_flag
        && !overflow_clear |=> receive_overflow_flag)
        else $error("overflow flag dropped without a clear");
    rx_hold_a: assert property (rx_valid && !rx_ready && clk_en
        |=> rx_valid && $stable(rx_data))
        else $error("received word changed before it was taken");
endmodule

// ---- tb/ssp_slave_model.sv ----
`timescale 1ns/10ps

// --------------------------------------------------------------
// far-side slave: replies with last word seen xor A5
// --------------------------------------------------------------
module ssp_slave_model (
    input wire logic sclk,
    input wire logic select_n,
    input wire logic mosi,
    input wire logic framed,
    input wire logic frame_pol,
    output logic miso
);
    logic [7:0] prev = 8'h3C;
    logic [7:0] out_q = 8'h00;
    logic [7:0] in_q = 8'h00;
    logic armed = 1'b0;
    int cnt = 0;
    logic [7:0] seen[$];

    // outside framed mode the unselected line shows the inverse, never a held value
    assign miso = (framed || !select_n) ? out_q[7] : ~out_q[7];
    always @(negedge select_n)
        if (!framed)
        begin
            out_q = prev ^ 8'hA5;
            cnt = 0;
        end
    always @(posedge sclk)
        if (framed && !armed && cnt == 0)
        begin
            armed = (select_n == frame_pol);
            out_q = prev ^ 8'hA5;
        end
        else if (framed || !select_n)
        begin
            in_q = {in_q[6:0], mosi};
            cnt++;
            if (cnt == 8)
            begin
                seen.push_back(in_q);
                prev = in_q;
                cnt = 0;
                armed = 1'b0;
            end
        end
    always @(negedge sclk)
        if (cnt != 0)
            out_q = out_q << 1;
endmodule

// ---- tb/ssp_port_bench.sv ----
`timescale 1ns/10ps

module ssp_port_bench;
    logic ref_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    ssp_pkg::ssp_cfg_t cfg = '0;
    logic [7:0] half_period = 8'h03;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic overflow_clear = 1'b0;
    logic sel_drv = 1'b1;
    logic sdi_drv = 1'b0;
    logic tx_ready, rx_valid, flag, busy, miso;
    logic [7:0] rx_data;
    ssp_pkg::ssp_pin_t dout, sclk, fsel;
    logic [31:0] seed = 32'h00000030;
    logic [7:0] prev = 8'h3C;
    logic [7:0] w;
    logic [7:0] exp_tx[$];
    logic [7:0] exp_rx[$];
    int errors = 0;
    int comparisons = 0;
    int n;

    ssp_port ssp_port_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
        .link_clk(link_clk), .cfg(cfg), .half_period(half_period),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .overflow_clear(overflow_clear), .receive_overflow_flag(flag),
        .busy(busy), .serial_in_pin(cfg.master_select ? miso : sdi_drv),
        .serial_out_pin(dout), .shift_clock_pin(sclk),
        .shift_clock_pin_i(sclk.oe_n ? link_clk : sclk.o),
        .select_or_frame_pin_i(fsel.oe_n ? sel_drv : fsel.o),
        .select_or_frame_pin(fsel));
    ssp_slave_model partner_inst (
        .sclk(sclk.oe_n ? 1'b0 : sclk.o), .select_n(fsel.oe_n | fsel.o),
        .mosi(dout.o), .framed(cfg.frame_enable),
        .frame_pol(cfg.frame_active_high), .miso(miso));

    initial forever #12.5 ref_clk = ~ref_clk;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic check8(string what, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check1(string what, logic e, logic g);
        check8(what, {7'h00, e}, {7'h00, g});
    endtask
    task automatic note(logic [7:0] v);
        exp_tx.push_back(v);
        exp_rx.push_back(prev ^ 8'hA5);
        prev = v;
    endtask
    // valid stays up between calls so back-to-back words never gap
    task automatic put(logic [7:0] v);
        int k = 0;
        tx_data <= v;
        tx_valid <= 1'b1;
        do @(posedge ref_clk); while (tx_ready !== 1'b1 && ++k < 5000);
    endtask
    task automatic send();
        w = rnd();
        note(w);
        put(w);
    endtask
    task automatic get(string what, logic [7:0] e);
        int k = 0;
        rx_ready <= 1'b1;
        do @(posedge ref_clk); while (rx_valid !== 1'b1 && ++k < 5000);
        check8(what, e, rx_data);
    endtask
    task automatic setcfg(logic m, logic enh, ssp_pkg::ssp_pins_t p,
        logic fr, logic pol, logic en);
        ssp_pkg::ssp_cfg_t c;
        c = '0;
        c.master_select = m;
        c.enhanced_mode = enh;
        c.pins = p;
        c.select_pin_enable = (p == ssp_pkg::SSP_PINS_4);
        c.frame_enable = fr;
        c.frame_active_high = pol;
        cfg <= c;
        overflow_clear <= 1'b1;
        half_period <= 8'h03 + (rnd() & 8'h03);
        @(posedge ref_clk);
        c.port_enable = en;
        cfg <= c;
        overflow_clear <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wait_idle();
        int k = 0;
        do @(posedge ref_clk);
        while ((partner_inst.seen.size() < exp_tx.size() || busy !== 1'b0)
            && ++k < 20000);
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic check_seen();
        while (exp_tx.size() > 0 && partner_inst.seen.size() > 0)
            check8("partner_word", exp_tx.pop_front(),
                partner_inst.seen.pop_front());
        check8("partner_left", 8'h00, 8'(exp_tx.size()));
    endtask
    task automatic slave_xfer(logic [7:0] d, logic [7:0] r, logic s,
        logic f);
        logic [7:0] got;
        int k = 0;
        put(r);
        tx_valid <= 1'b0;
        do @(posedge ref_clk); while (busy !== 1'b1 && ++k < 100);
        if (f)
        begin
            sel_drv <= cfg.frame_active_high;
            #7.5;
            link_clk <= 1'b1;
            #7.5;
            link_clk <= 1'b0;
        end
        sel_drv <= f ? !cfg.frame_active_high : s;
        for (int i = 7; i >= 0; i--)
        begin
            sdi_drv <= d[i];
            #7.5;
            got[i] = dout.o;
            link_clk <= 1'b1;
            #7.5;
            link_clk <= 1'b0;
        end
        sel_drv <= 1'b1;
        get("slave_rx", d);
        rx_ready <= 1'b0;
        check8("slave_tx", r, got);
    endtask
    task automatic conclude();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        setcfg(1'b1, 1'b0, ssp_pkg::SSP_PINS_4, 1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 3; i++) send();
        tx_valid <= 1'b0;
        for (int i = 0; i < 3; i++) get("word", exp_rx.pop_front());
        rx_ready <= 1'b0;
        wait_idle();
        check_seen();
        $display("test master_words done");
        for (int m = 0; m < 2; m++)
        begin
            n = 0;
            setcfg(1'b1, m[0], ssp_pkg::SSP_PINS_4, 1'b0, 1'b0, 1'b0);
            do
            begin
                w = rnd();
                tx_data <= w;
                tx_valid <= 1'b1;
                @(posedge ref_clk);
                if (tx_ready === 1'b1)
                begin
                    note(w);
                    n++;
                end
            end while (tx_ready === 1'b1 && n < 12);
            tx_valid <= 1'b0;
            check8("depth", m ? 8'h08 : 8'h01, 8'(n));
            setcfg(1'b1, m[0], ssp_pkg::SSP_PINS_4, 1'b0, 1'b0, 1'b1);
            send();
            tx_valid <= 1'b0;
            wait_idle();
            check1("overflow_set", 1'b1, flag);
            for (int i = 0; i < n; i++) get("held", exp_rx.pop_front());
            w = exp_rx.pop_front();
            rx_ready <= 1'b0;
            overflow_clear <= 1'b1;
            @(posedge ref_clk);
            overflow_clear <= 1'b0;
            check1("rx_empty", 1'b0, rx_valid);
            @(posedge ref_clk);
            check1("overflow_clear", 1'b0, flag);
            check_seen();
        end
        $display("test buffer_depth done");
        for (int p = 0; p < 2; p++)
        begin
            setcfg(1'b1, 1'b0, ssp_pkg::SSP_PINS_4, 1'b1, p[0], 1'b1);
            send();
            tx_valid <= 1'b0;
            get("framed", exp_rx.pop_front());
            rx_ready <= 1'b0;
            wait_idle();
            check_seen();
        end
        $display("test framed done");
        setcfg(1'b1, 1'b0, ssp_pkg::SSP_PINS_2, 1'b0, 1'b0, 1'b1);
        check1("two_pin_out", 1'b1, dout.oe_n);
        check1("two_pin_sel", 1'b1, fsel.oe_n);
        for (int p = 0; p < 4; p++)
        begin
            check1("buffer_clear", 1'b1, tx_ready);
            setcfg(1'b0, 1'b0, p == 1 ? ssp_pkg::SSP_PINS_3 :
                ssp_pkg::SSP_PINS_4, p[1], p[0], 1'b1);
            check1("slave_sel", 1'b1, fsel.oe_n);
            check1("slave_out", 1'b0, dout.oe_n);
            slave_xfer(rnd(), rnd(), p[0], p[1]);
        end
        $display("test pins_and_slave done");
        conclude();
    end

    // whole run needs well under a millisecond
    initial
    begin
        #1000000;
        errors++;
        $display("mismatch watchdog expected end seen hang");
        conclude();
    end
endmodule

bind ssp_port ssp_port_properties #(.W(W)) props_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .cfg(cfg),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready),
    .overflow_clear(overflow_clear),
    .receive_overflow_flag(receive_overflow_flag), .busy(busy),
    .serial_out_pin(serial_out_pin), .shift_clock_pin(shift_clock_pin),
    .select_or_frame_pin(select_or_frame_pin));
